// [src/tpg_pkg.sv]
// package: constants for the test pattern generator
`default_nettype none
package tpg_pkg;
  // ------------------------------------------------------------
  // pattern types
  // ------------------------------------------------------------
  localparam logic [1:0] TPG_TYPE_PRBS  = 2'h0;
  localparam logic [1:0] TPG_TYPE_ZSUB  = 2'h1;
  localparam logic [1:0] TPG_TYPE_DATA  = 2'h2;
  localparam logic [1:0] TPG_TYPE_MIXED = 2'h3;
  // ------------------------------------------------------------
  // widths and sizes
  // ------------------------------------------------------------
  localparam int TPG_MEM_AW    = 12;
  localparam int TPG_MEM_DEPTH = 4096;
  localparam int TPG_LW        = 16;
  localparam int TPG_ZW        = 24;
  localparam int TPG_BW        = 9;
  localparam int TPG_RW        = 8;
  localparam logic [TPG_RW-1:0] TPG_MIN_ROWS = 8'h02;
  localparam logic [2:0] TPG_STG_MAX_ZSUB = 3'h6;
  localparam logic [2:0] TPG_STG_31       = 3'h7;
  // ------------------------------------------------------------
  // sequence tables, indexed by the stage select 0..7
  // ------------------------------------------------------------
  localparam logic [4:0] TPG_N [0:7] =
    '{5'h07, 5'h09, 5'h0A, 5'h0B, 5'h0F, 5'h14, 5'h17, 5'h1F};
  localparam logic [4:0] TPG_TAP_HI [0:7] =
    '{5'h06, 5'h08, 5'h09, 5'h0A, 5'h0E, 5'h13, 5'h16, 5'h1E};
  localparam logic [4:0] TPG_TAP_LO [0:7] =
    '{5'h05, 5'h04, 5'h06, 5'h08, 5'h0D, 5'h02, 5'h11, 5'h1B};
  // ------------------------------------------------------------
  // reset values and seeds
  // ------------------------------------------------------------
  localparam logic [30:0] TPG_SEED31 = 31'h7FFFFFFF;
  localparam logic [6:0]  TPG_SEED7  = 7'h7F;
  localparam logic [TPG_LW-1:0] TPG_LEN_RST = 16'h0000;
  localparam logic [TPG_BW-1:0] TPG_BLK_RST = 9'h000;
endpackage
`default_nettype wire

// [src/tpg_stream_if.sv]
// interface: one-bit valid/ready stream between generator and buffer
`default_nettype none
interface tpg_stream_if;
  logic valid;
  logic ready;
  logic data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [src/tpg_buf2.sv]
// module: two-entry buffer in the serial data path
`default_nettype none
module tpg_buf2 (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  srst,
  // filling side
  tpg_stream_if.snk  up,
  // draining side
  output var logic   out_valid,
  output var logic   out_data,
  input  wire logic  out_ready
);
  logic v1_r;
  logic d1_r;
  wire  push = up.valid & up.ready;
  wire  pop  = out_valid & out_ready;

  // a full buffer holds the generator still, no word is dropped
  assign up.ready = ~v1_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_data  <= 1'b0;
      v1_r      <= 1'b0;
      d1_r      <= 1'b0;
    end else if (pop) begin
      out_valid <= v1_r | push;
      out_data  <= v1_r ? d1_r : up.data;
      v1_r      <= v1_r & push;
      d1_r      <= up.data;
    end else if (push) begin
      out_valid <= 1'b1;
      if (out_valid) begin
        v1_r <= 1'b1;
        d1_r <= up.data;
      end else begin
        out_data <= up.data;
      end
    end
  end

  AST_BUF_HOLD: assert property (@(posedge clk) disable iff (srst)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer dropped or changed a stalled word");
endmodule
`default_nettype wire

// [src/tpg_top.sv]
// module: serial test pattern generator with pattern memory
`default_nettype none
// ------------------------------------------------------------
// Overview of operation
// - four pattern types: prbs, zero-substituted, programmed data, mixed
// - prbs period 2^n-1, n one of 7,9,10,11,15,20,23,31
// - in prbs type, true polarity drives logic 0 high
// - other types, true polarity drives logic 1 high
// - zero-substituted length 2^n or 2^n-1, n up to 23
// - substituted zero count 1..2^n-2 or 1..2^n-1, single-bit steps
// - at length 2^n the last bit is forced to chosen value
// - selecting zero-sub or data type starts a load, loading flag held
// - mixed row is data then prbs; blocks hold two or more rows
// - at most 511 blocks; total block count reported
// - row length, data length and rows per block reported
// - scramble on applies prbs7 to selected mixed areas
// - scramble off passes the selected areas unmodified
// - first-row data segment of each block is never scrambled
// - restart mode reseeds the prbs at each block start
// ------------------------------------------------------------
module tpg_top
  import tpg_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // pattern configuration
  input  wire logic [1:0]        pat_type,
  input  wire logic [2:0]        prbs_stages,
  input  wire logic              inverted_polarity,
  input  wire logic              zs_len_pow2,
  input  wire logic [TPG_ZW-1:0] zs_zero_count,
  input  wire logic              zs_last_bit,
  // mixed pattern configuration
  input  wire logic              scramble_en,
  input  wire logic              scr_data_en,
  input  wire logic              scr_prbs_en,
  input  wire logic              restart_mode,
  input  wire logic [TPG_LW-1:0] cfg_row_len,
  input  wire logic [TPG_LW-1:0] cfg_data_len,
  input  wire logic [TPG_RW-1:0] cfg_rows,
  input  wire logic [TPG_BW-1:0] cfg_blocks,
  // pattern memory load
  input  wire logic              reload_req,
  input  wire logic              ld_valid,
  input  wire logic              ld_bit,
  input  wire logic              ld_last,
  output var  logic              ld_ready,
  output var  logic              loading,
  // loaded pattern report
  output var  logic [TPG_LW-1:0] pat_len_o,
  output var  logic [TPG_BW-1:0] blk_count_o,
  output var  logic [TPG_LW-1:0] row_len_o,
  output var  logic [TPG_LW-1:0] data_len_o,
  output var  logic [TPG_RW-1:0] rows_o,
  // serial output
  output var  logic              ser_valid,
  output var  logic              ser_data,
  input  wire logic              ser_ready
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic                  mem_r [0:TPG_MEM_DEPTH-1];
  logic [1:0]            type_r;
  logic [2:0]            stg_r;
  logic                  loading_r;
  logic [TPG_MEM_AW-1:0] wr_addr_r;
  logic [TPG_MEM_AW-1:0] rd_addr_r;
  logic [30:0]           lfsr_r;
  logic [6:0]            scr_r;
  logic [TPG_ZW-1:0]     zs_cnt_r;
  logic [TPG_LW-1:0]     bit_cnt_r;
  logic [TPG_RW-1:0]     row_r;
  logic [TPG_BW-1:0]     blk_r;
  tpg_stream_if          up ();

  // ------------------------------------------------------------
  // decoding
  // ------------------------------------------------------------
  wire is_prbs  = (type_r == TPG_TYPE_PRBS);
  wire is_zsub  = (type_r == TPG_TYPE_ZSUB);
  wire is_data  = (type_r == TPG_TYPE_DATA);
  wire is_mixed = (type_r == TPG_TYPE_MIXED);
  // zero-sub has no 31-stage base, it falls back to 23 stages
  wire [2:0] stg = (is_zsub && stg_r == TPG_STG_31) ?
                   TPG_STG_MAX_ZSUB : stg_r;
  wire [4:0] hi  = TPG_TAP_HI[stg];
  wire [4:0] lo  = TPG_TAP_LO[stg];
  wire       prbs_bit = lfsr_r[hi];
  wire       fb       = lfsr_r[hi] ^ lfsr_r[lo];
  wire [30:0] lfsr_step = {lfsr_r[29:0], fb};
  wire [6:0]  scr_step  = {scr_r[5:0], scr_r[6] ^ scr_r[5]};

  // zero-substituted geometry
  wire [TPG_ZW-1:0] base_len =
    (TPG_ZW'(1) << TPG_N[stg]) - TPG_ZW'(1);
  wire [TPG_ZW-1:0] zs_last = base_len - {23'h0, ~zs_len_pow2};
  wire [TPG_ZW-1:0] zs_zero =
    (zs_zero_count == '0) ? TPG_ZW'(1) :
    (zs_zero_count > zs_last) ? zs_last : zs_zero_count;
  wire zs_end   = (zs_cnt_r == zs_last);
  wire zs_fill  = (zs_cnt_r < zs_zero);
  wire zs_extra = zs_len_pow2 && (zs_cnt_r == base_len);

  // mixed geometry
  wire in_data  = (bit_cnt_r < data_len_o);
  wire row_end  = (bit_cnt_r == row_len_o - TPG_LW'(1));
  wire blk_end  = row_end && (row_r == rows_o - TPG_RW'(1));
  wire pat_end  = blk_end && (blk_r == blk_count_o - TPG_BW'(1));
  wire rd_wrap  = ({4'h0, rd_addr_r} == pat_len_o - TPG_LW'(1));
  wire mem_bit  = mem_r[rd_addr_r];

  // pattern source per type
  wire raw_bit =
    is_prbs ? prbs_bit :
    is_zsub ? (zs_fill ? 1'b0 :
               zs_extra ? zs_last_bit : prbs_bit) :
    is_data ? mem_bit :
    (in_data ? mem_bit : prbs_bit);
  wire scr_sel = is_mixed && scramble_en &&
                 (in_data ? (scr_data_en && row_r != '0)
                          : scr_prbs_en);
  wire scr_bit = raw_bit ^ (scr_sel & scr_r[6]);
  wire out_bit = is_prbs ? ~(scr_bit ^ inverted_polarity)
                         : scr_bit ^ inverted_polarity;

  // generation control
  wire cfg_chg   = (pat_type != type_r) || (prbs_stages != stg_r);
  wire load_go   = reload_req ||
                   ((pat_type != type_r) &&
                    (pat_type == TPG_TYPE_ZSUB ||
                     pat_type == TPG_TYPE_DATA));
  wire ld_take   = loading_r && ld_valid;
  wire ld_done   = ld_take && ld_last;
  wire mem_ok    = (pat_len_o != '0);
  wire mix_ok    = mem_ok && blk_count_o != '0 && row_len_o != '0;
  wire gen_ok    = is_prbs || is_zsub || (is_data && mem_ok) ||
                   (is_mixed && mix_ok);
  wire go        = gen_ok && !loading_r && !cfg_chg;
  wire adv       = go && up.ready;
  wire prbs_adv  = adv && (is_prbs ||
                   (is_zsub && zs_cnt_r < base_len) ||
                   (is_mixed && !in_data));
  wire reseed    = adv && is_mixed && blk_end && restart_mode;

  assign up.valid = go;
  assign up.data  = out_bit;
  assign ld_ready = loading_r;
  assign loading  = loading_r;

  // ------------------------------------------------------------
  // configuration tracking and memory load
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      type_r    <= TPG_TYPE_PRBS;
      stg_r     <= 3'h0;
      loading_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      type_r <= pat_type;
      stg_r  <= prbs_stages;
      if (load_go) begin
        loading_r <= 1'b1;
        wr_addr_r <= '0;
      end else if (ld_done) begin
        loading_r <= 1'b0;
      end else if (ld_take) begin
        wr_addr_r <= wr_addr_r + TPG_MEM_AW'(1);
      end
    end
  end

  // memory has no reset; a load always rewrites what it reports
  always_ff @(posedge clk) begin
    if (ld_take && !load_go) begin
      mem_r[wr_addr_r] <= ld_bit;
    end
  end

  // geometry is captured with the load so it matches the memory
  always_ff @(posedge clk) begin
    if (srst) begin
      pat_len_o   <= TPG_LEN_RST;
      blk_count_o <= TPG_BLK_RST;
      row_len_o   <= TPG_LEN_RST;
      data_len_o  <= TPG_LEN_RST;
      rows_o      <= TPG_MIN_ROWS;
    end else if (ld_done && !load_go) begin
      pat_len_o   <= {4'h0, wr_addr_r} + TPG_LW'(1);
      blk_count_o <= cfg_blocks;
      row_len_o   <= cfg_row_len;
      data_len_o  <= cfg_data_len;
      rows_o      <= (cfg_rows < TPG_MIN_ROWS) ?
                     TPG_MIN_ROWS : cfg_rows;
    end
  end

  // ------------------------------------------------------------
  // sequence generators
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || cfg_chg || loading_r) begin
      lfsr_r <= TPG_SEED31;
      scr_r  <= TPG_SEED7;
    end else begin
      if (reseed) begin
        lfsr_r <= TPG_SEED31;
      end else if (prbs_adv) begin
        lfsr_r <= lfsr_step;
      end
      if (adv && is_mixed) begin
        scr_r <= scr_step;
      end
    end
  end

  // ------------------------------------------------------------
  // position counters
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || cfg_chg || loading_r) begin
      zs_cnt_r  <= '0;
      bit_cnt_r <= '0;
      row_r     <= '0;
      blk_r     <= '0;
      rd_addr_r <= '0;
    end else if (adv) begin
      zs_cnt_r <= zs_end ? '0 : zs_cnt_r + TPG_ZW'(1);
      if (is_data || (is_mixed && in_data)) begin
        rd_addr_r <= rd_wrap ? '0 : rd_addr_r + TPG_MEM_AW'(1);
      end
      if (is_mixed) begin
        bit_cnt_r <= row_end ? '0 : bit_cnt_r + TPG_LW'(1);
        if (row_end) begin
          row_r <= blk_end ? '0 : row_r + TPG_RW'(1);
        end
        if (blk_end) begin
          blk_r <= pat_end ? '0 : blk_r + TPG_BW'(1);
        end
        if (pat_end) begin
          rd_addr_r <= '0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // output buffer
  // ------------------------------------------------------------
  tpg_buf2 u_buf (
    .clk       (clk),
    .srst      (srst),
    .up        (up.snk),
    .out_valid (ser_valid),
    .out_data  (ser_data),
    .out_ready (ser_ready)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_load_done;
    loading_r && ld_valid && ld_last && !load_go;
  endsequence

  AST_PRBS_POL: assert property (
    adv && is_prbs |-> up.data == (prbs_bit ~^ inverted_polarity))
    else $error("prbs polarity wrong");
  AST_OTHER_POL: assert property (
    adv && !is_prbs |-> up.data == (scr_bit ^ inverted_polarity))
    else $error("non-prbs polarity wrong");
  AST_LOAD_START: assert property (
    (pat_type == TPG_TYPE_DATA) && (type_r != TPG_TYPE_DATA)
    |=> loading_r && !up.valid)
    else $error("data type selection did not start a load");
  AST_LOAD_HOLD: assert property (
    loading_r && !(ld_valid && ld_last) |=> loading_r)
    else $error("loading flag dropped early");
  AST_LEN_REPORT: assert property (
    s_load_done |=> !loading_r &&
      pat_len_o == {4'h0, $past(wr_addr_r)} + TPG_LW'(1))
    else $error("loaded length not reported");
  AST_ZERO_FILL: assert property (
    adv && is_zsub && zs_cnt_r < zs_zero |-> raw_bit == 1'b0)
    else $error("substituted bit not zero");
  AST_LAST_BIT: assert property (
    adv && is_zsub && zs_len_pow2 && zs_cnt_r == base_len
    |-> raw_bit == zs_last_bit)
    else $error("last bit of 2^n pattern wrong");
  AST_FIRST_ROW: assert property (
    adv && is_mixed && row_r == '0 && in_data |-> scr_bit == mem_bit)
    else $error("first row data was scrambled");
  AST_SCR_OFF: assert property (
    adv && !scramble_en |-> scr_bit == raw_bit)
    else $error("scramble applied while off");
  AST_RESTART: assert property (
    reseed |=> lfsr_r == TPG_SEED31)
    else $error("prbs not restarted at block start");
  AST_CONSEC: assert property (
    adv && is_mixed && blk_end && !restart_mode && !in_data && !cfg_chg
    |=> lfsr_r == $past(lfsr_step))
    else $error("prbs not carried across block");
  AST_BLK_RANGE: assert property (
    is_mixed && mix_ok |-> blk_r < blk_count_o)
    else $error("block index beyond block count");
endmodule
`default_nettype wire

// [verif/tpg_sink.sv]
// partner model: serial receiver that can stall the stream
`default_nettype none
module tpg_sink (
  // clock
  input  wire logic clk,
  // stream handshake
  output var  logic ser_ready,
  // stall control
  input  wire logic slow
);
  timeunit 1ns;
  timeprecision 1ps;
  // ready is unknown only until the first falling edge, inside reset
  logic [1:0] ph_r = 2'h0;
  // slow takes one word in four, so the buffer fills and must hold
  always @(posedge clk) ph_r <= ph_r + 2'h1;
  always @(negedge clk) ser_ready <= !slow || (ph_r == 2'h0);
endmodule
`default_nettype wire

// [verif/tpg_top_tb.sv]
// testbench: pattern types, load stream and serial output checks
`default_nettype none
module tpg_top_tb;
  import tpg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // stimulus and observation
  // ------------------------------------------------------------
  localparam logic [31:0] MEMV = 32'hC3A55A3C;
  logic clk = 1'b0, srst = 1'b1, slow = 1'b0;
  logic [1:0] pat_type = 2'h0;
  logic [2:0] prbs_stages = 3'h0;
  logic inverted_polarity = 1'b0, zs_len_pow2 = 1'b0, zs_last_bit = 1'b0;
  logic [TPG_ZW-1:0] zs_zero_count = 24'h000005;
  logic scramble_en = 1'b0, scr_data_en = 1'b1, scr_prbs_en = 1'b0;
  logic restart_mode = 1'b1, reload_req = 1'b0;
  logic ld_valid = 1'b0, ld_bit = 1'b0, ld_last = 1'b0;
  logic [TPG_LW-1:0] cfg_row_len = 16'h0010, cfg_data_len = 16'h0008;
  logic [TPG_RW-1:0] cfg_rows = 8'h02;
  logic [TPG_BW-1:0] cfg_blocks = 9'h002;
  logic ld_ready, loading, ser_valid, ser_data, ser_ready;
  logic [TPG_LW-1:0] pat_len_o, row_len_o, data_len_o;
  logic [TPG_BW-1:0] blk_count_o;
  logic [TPG_RW-1:0] rows_o;
  logic cap[$];
  logic [127:0] va, vb, vc, vd;
  int fail_count = 0, samples_checked = 0;
  int p, d, e, f, g, h, z;

  always #5 clk = ~clk;
  always @(posedge clk) if (ser_valid === 1'b1 && ser_ready === 1'b1)
    cap.push_back(ser_data);

  tpg_top i_dut (.clk(clk), .srst(srst), .pat_type(pat_type),
    .prbs_stages(prbs_stages), .inverted_polarity(inverted_polarity),
    .zs_len_pow2(zs_len_pow2), .zs_zero_count(zs_zero_count),
    .zs_last_bit(zs_last_bit), .scramble_en(scramble_en),
    .scr_data_en(scr_data_en), .scr_prbs_en(scr_prbs_en),
    .restart_mode(restart_mode), .cfg_row_len(cfg_row_len),
    .cfg_data_len(cfg_data_len), .cfg_rows(cfg_rows),
    .cfg_blocks(cfg_blocks), .reload_req(reload_req),
    .ld_valid(ld_valid), .ld_bit(ld_bit), .ld_last(ld_last),
    .ld_ready(ld_ready), .loading(loading), .pat_len_o(pat_len_o),
    .blk_count_o(blk_count_o), .row_len_o(row_len_o),
    .data_len_o(data_len_o), .rows_o(rows_o), .ser_valid(ser_valid),
    .ser_data(ser_data), .ser_ready(ser_ready));

  tpg_sink i_rx (.clk(clk), .ser_ready(ser_ready), .slow(slow));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // type is applied inside reset so release starts from a clean stream
  task automatic rst(input logic [1:0] t);
    @(negedge clk);
    srst = 1'b1;
    pat_type = t;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    cap.delete();
  endtask

  task automatic load(input logic [31:0] v, input int n);
    int w;
    w = 0;
    while (loading !== 1'b1 && w < 20) begin
      @(negedge clk);
      w++;
    end
    chk(loading, 1);
    chk(ld_ready, 1);
    for (int k = 0; k < n; k++) begin
      ld_valid = 1'b1;
      ld_bit = v[k];
      ld_last = (k == n - 1);
      @(negedge clk);
    end
    ld_valid = 1'b0;
    ld_last = 1'b0;
    @(negedge clk);
    chk(loading, 0);
    cap.delete();
  endtask

  task automatic grab(input int n);
    int w;
    w = 0;
    while (cap.size() < n && w < 20000) begin
      @(negedge clk);
      w++;
    end
    chk(cap.size() >= n, 1);
  endtask

  task automatic mixed(input logic rs, input logic sc,
                       output logic [127:0] v);
    restart_mode = rs;
    scramble_en = sc;
    rst(TPG_TYPE_MIXED);
    repeat (2) @(negedge clk);
    reload_req = 1'b1;
    @(negedge clk);
    reload_req = 1'b0;
    load(MEMV, 32);
    grab(128);
    for (int k = 0; k < 128; k++) v[k] = cap[k];
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    for (int s = 0; s < 4; s++) begin
      prbs_stages = s[2:0];
      inverted_polarity = s[0];
      rst(TPG_TYPE_PRBS);
      p = (1 << TPG_N[s]) - 1;
      grab(2 * p);
      d = 0;
      h = 0;
      for (int k = 0; k < p; k++) begin
        d += (cap[k] !== cap[k + p]);
        h += (cap[k] === 1'b1);
      end
      chk(d, 0);
      chk(h, s[0] ? (p + 1) / 2 : (p - 1) / 2);
      $display("test prbs stage %0d done", s);
    end
    prbs_stages = 3'h0;
    inverted_polarity = 1'b0;
    // zeroed bits are taken from the seed run, which is all ones
    for (int c = 0; c < 3; c++) begin
      zs_len_pow2 = (c != 2);
      zs_last_bit = (c != 0);
      z = 5 - c;
      zs_zero_count = z[TPG_ZW-1:0];
      rst(TPG_TYPE_ZSUB);
      load(32'h1, 1);
      p = zs_len_pow2 ? 128 : 127;
      grab(2 * p);
      d = 0;
      h = 0;
      for (int k = 0; k < p; k++) begin
        d += (cap[k] !== cap[k + p]);
        h += (cap[k] === 1'b1);
      end
      chk(d, 0);
      chk(h, 64 - z + (zs_len_pow2 & zs_last_bit));
      chk({cap[z - 1], cap[z]}, 2'h1);
      if (zs_len_pow2) chk(cap[127], zs_last_bit);
      $display("test zero substitution case %0d done", c);
    end
    // in pass 1 the slow receiver keeps the two-entry buffer full while checking; pass 0 runs with the receiver always ready
    for (int c = 0; c < 2; c++) begin
      inverted_polarity = c[0];
      slow = c[0];
      rst(TPG_TYPE_DATA);
      load(32'h1B35, 13);
      chk(pat_len_o, 13);
      grab(26);
      d = 0;
      for (int k = 0; k < 26; k++) d += (cap[k] !== (MEMV[0] ^ 1'b0 ^
        (32'h1B35 >> (k % 13)) & 1'b1 ^ c[0] ^ MEMV[0]));
      chk(d, 0);
      $display("test data polarity %0d done", c);
    end
    slow = 1'b0;
    inverted_polarity = 1'b0;
    mixed(1'b1, 1'b0, va);
    mixed(1'b0, 1'b0, vb);
    mixed(1'b1, 1'b1, vc);
    // only the prbs areas selected this time
    scr_data_en = 1'b0;
    scr_prbs_en = 1'b1;
    mixed(1'b1, 1'b1, vd);
    chk(blk_count_o, 2);
    chk({row_len_o, data_len_o}, {16'h0010, 16'h0008});
    chk(rows_o, 2);
    d = 0;
    e = 0;
    f = 0;
    g = 0;
    h = 0;
    for (int k = 0; k < 128; k++) begin
      if (!k[3]) d += (va[k] !== MEMV[{k[5], k[4], k[2:0]}]) +
                      (vb[k] !== MEMV[{k[5], k[4], k[2:0]}]);
      if (k[3]) e += (va[k] !== va[k ^ 32]);
      if (k[3] && k[5]) f += (vb[k] !== va[k]);
      if (k[3] || !k[4]) g += (vc[k] !== va[k]);
      else h += (vc[k] !== va[k]);
    end
    chk(d, 0);
    chk(e, 0);
    chk(f != 0, 1);
    chk(g, 0);
    chk(h != 0, 1);
    d = 0;
    h = 0;
    for (int k = 0; k < 128; k++) begin
      if (k[3]) h += (vd[k] !== va[k]);
      else d += (vd[k] !== va[k]);
    end
    chk(d, 0);
    chk(h != 0, 1);
    $display("test mixed done");
    summarize();
  end
endmodule
`default_nettype wire
